// ### hw/smbus_clock_buffer_pkg.sv
package smbus_clock_buffer_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] REG_OE     = 8'h00;
  localparam logic [7:0] REG_PLL    = 8'h01;
  localparam logic [7:0] REG_SLEW   = 8'h02;
  localparam logic [7:0] REG_FREQ   = 8'h03;
  localparam logic [7:0] REG_RSVD   = 8'h04;
  localparam logic [7:0] REG_REVVEN = 8'h05;
  localparam logic [7:0] REG_TYPEID = 8'h06;
  localparam logic [7:0] REG_LEN    = 8'h07;
  localparam logic [6:0] TARGET_ADDR = 7'h6d;
  // ************************************************************
  // reset values and fixed masks (writable bits, read-back fill)
  // ************************************************************
  localparam logic [7:0] OE_RESET    = 8'hff;
  localparam logic [7:0] OE_WMASK    = 8'h28;
  localparam logic [7:0] PLL_RESET   = 8'h06;
  localparam logic [7:0] PLL_WMASK   = 8'h3b;
  localparam logic [7:0] SLEW_RESET  = 8'hff;
  localparam logic [7:0] SLEW_WMASK  = 8'h28;
  localparam logic [7:0] FREQ_RESET  = 8'h07;
  localparam logic [7:0] FREQ_WMASK  = 8'h39;
  localparam logic [7:0] RSVD_VALUE  = 8'hff;
  localparam logic [7:0] LEN_RESET   = 8'h08;
  localparam logic [7:0] LEN_WMASK   = 8'h1f;
  localparam int OE1_BIT = 5;
  localparam int OE0_BIT = 3;
  localparam int SWSEL_BIT = 5;
  localparam int FSEL_EN_BIT = 5;
  localparam int FB_SLEW_BIT = 0;
  // ************************************************************
  // decoded modes
  // ************************************************************
  typedef enum logic [1:0] {
    PLL_LOW_BW  = 2'b00,
    PLL_BYPASS  = 2'b01,
    PLL_RSVD    = 2'b10,
    PLL_HIGH_BW = 2'b11
  } pll_mode_t;
  typedef struct packed {
    logic      output1Enable;
    logic      output0Enable;
    pll_mode_t pllMode;
    logic [1:0] amplitude;
    logic      output1Slew;
    logic      output0Slew;
    logic      feedbackSlew;
    logic      freqSelectValid;
    logic [1:0] freqCode;
  } clock_cfg_t;
endpackage

// ### hw/smbus_clock_buffer_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_clock_buffer_config_regs
  import smbus_clock_buffer_pkg::*;
#(
  parameter logic [3:0] REVISION_CODE = 4'h3,  // arbitrary value
  parameter logic [3:0] VENDOR_CODE   = 4'h5,  // arbitrary value
  parameter logic [1:0] PART_TYPE     = 2'h2,  // arbitrary value
  parameter logic [5:0] PART_ID       = 6'h2a  // arbitrary value
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // smbus pins
  input  wire logic       smbClk,
  input  wire logic       smbDataIn,
  output logic            smbDataOut,
  output logic            smbDataOe,
  // strap
  input  wire logic [1:0] bandwidthModePin,
  // decoded configuration
  output clock_cfg_t      clockCfg
);
  // ************************************************************
  // pin synchronisers and edge detection
  // ************************************************************
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic       sclPrev;
  logic       sdaPrev;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sclSync <= 2'b11;
      sdaSync <= 2'b11;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], smbClk};
      sdaSync <= {sdaSync[0], smbDataIn};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end
  wire scl      = sclSync[1];
  wire sda      = sdaSync[1];
  wire sclRise  = scl & ~sclPrev;
  wire sclFall  = ~scl & sclPrev;
  wire startSeen = scl & sclPrev & sdaPrev & ~sda;
  wire stopSeen  = scl & sclPrev & ~sdaPrev & sda;

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] oeReg;
  logic [7:0] pllReg;
  logic [7:0] slewReg;
  logic [7:0] freqReg;
  logic [7:0] lenReg;
  logic [1:0] latchedMode;
  logic       strapTaken;

  // ************************************************************
  // transaction state
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_INDEX = 3'b010,
    ST_COUNT = 3'b011,
    ST_WDATA = 3'b100,
    ST_RDATA = 3'b101,
    ST_IGNORE = 3'b110
  } phase_t;
  phase_t     phase;
  logic [3:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] shiftOut;
  logic [7:0] index;
  logic [7:0] remain;
  logic       ackSlot;
  logic       driveLow;
  logic       readDir;
  logic       hostNack;
  logic       firstRead;

  wire [7:0] byteIn = {shiftIn[6:0], sda};
  wire       byteDone = sclRise & (bitCnt == 4'd7) & ~ackSlot;
  wire       ackEnd   = sclFall & ackSlot;
  wire       addrHit  = (byteIn[7:1] == TARGET_ADDR);

  // read mux, reserved bits fixed by masks
  logic [7:0] readData;
  logic [7:0] next_rd;
  always_comb begin
    unique case (index)
      REG_OE:     readData = oeReg;
      REG_PLL:    readData = {latchedMode, pllReg[5:0]};
      REG_SLEW:   readData = slewReg;
      REG_FREQ:   readData = freqReg;
      REG_RSVD:   readData = RSVD_VALUE;
      REG_REVVEN: readData = {REVISION_CODE, VENDOR_CODE};
      REG_TYPEID: readData = {PART_TYPE, PART_ID};
      REG_LEN:    readData = lenReg;
      default:    readData = RSVD_VALUE;
    endcase
  end

  // write merge keeps reserved bits at default
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] data,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction
  wire wrStrobe = byteDone & (phase == ST_WDATA) & (remain != 8'h00);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      oeReg   <= OE_RESET;
      pllReg  <= PLL_RESET;
      slewReg <= SLEW_RESET;
      freqReg <= FREQ_RESET;
      lenReg  <= LEN_RESET;
    end else if (wrStrobe) begin
      unique case (index)
        REG_OE:   oeReg   <= merge(oeReg, byteIn, OE_WMASK);
        REG_PLL:  pllReg  <= merge(pllReg, byteIn, PLL_WMASK);
        REG_SLEW: slewReg <= merge(slewReg, byteIn, SLEW_WMASK);
        REG_FREQ: freqReg <= merge(freqReg, byteIn, FREQ_WMASK);
        REG_LEN:  lenReg  <= merge(lenReg, byteIn, LEN_WMASK);
        default:  ;
      endcase
    end
  end

  // strap passes two flops, then is taken once; later pin moves are ignored
  logic [1:0] modeMeta;
  logic [1:0] modeSync;
  logic [1:0] strapWait;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      modeMeta    <= 2'h0;
      modeSync    <= 2'h0;
      strapWait   <= 2'h0;
      latchedMode <= 2'h0;
      strapTaken  <= 1'b0;
    end else begin
      modeMeta <= bandwidthModePin;
      modeSync <= modeMeta;
      if (!strapTaken && strapWait == 2'h2) begin
        latchedMode <= modeSync;
        strapTaken  <= 1'b1;
      end else if (!strapTaken) begin
        strapWait <= strapWait + 2'h1;
      end
    end
  end

  // ************************************************************
  // protocol engine
  // ************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      phase     <= ST_IDLE;
      bitCnt    <= 4'd0;
      shiftIn   <= 8'h00;
      shiftOut  <= 8'hff;
      index     <= 8'h00;
      remain    <= 8'h00;
      ackSlot   <= 1'b0;
      driveLow  <= 1'b0;
      readDir   <= 1'b0;
      hostNack  <= 1'b0;
      firstRead <= 1'b0;
    end else if (stopSeen) begin
      phase    <= ST_IDLE;
      driveLow <= 1'b0;
      ackSlot  <= 1'b0;
    end else if (startSeen) begin
      phase    <= ST_ADDR;
      bitCnt   <= 4'd0;
      ackSlot  <= 1'b0;
      driveLow <= 1'b0;
    end else if (phase != ST_IDLE && phase != ST_IGNORE) begin
      if (sclRise && !ackSlot) begin
        shiftIn <= byteIn;
        bitCnt  <= bitCnt + 4'd1;
      end
      if (sclRise && ackSlot && readDir) begin
        hostNack <= sda;
      end
      if (byteDone) begin
        ackSlot <= 1'b1;
        bitCnt  <= 4'd0;
        unique case (phase)
          ST_ADDR: begin
            if (addrHit) begin
              readDir   <= byteIn[0];
              firstRead <= byteIn[0];
            end else begin
              phase <= ST_IGNORE;
            end
          end
          ST_INDEX: index <= byteIn;
          ST_COUNT: remain <= byteIn;
          ST_WDATA: begin
            if (remain != 8'h00) begin
              remain <= remain - 8'h01;
              index  <= index + 8'h01;
            end
          end
          default: ;
        endcase
      end
      // device drives ack after each received byte, except an address byte that does not match
      if (sclFall && bitCnt == 4'd0 && ackSlot && !driveLow
          && phase != ST_RDATA && !readDir) begin
        driveLow <= 1'b1;
      end else if (sclFall && ackSlot && phase == ST_ADDR && readDir
                   && !driveLow) begin
        driveLow <= 1'b1;
      end else if (ackEnd && driveLow) begin
        driveLow <= 1'b0;
        ackSlot  <= 1'b0;
        unique case (phase)
          ST_ADDR: begin
            if (readDir) begin
              phase    <= ST_RDATA;
              shiftOut <= {3'b000, lenReg[4:0]};
            end else begin
              phase <= ST_INDEX;
            end
          end
          ST_INDEX: phase <= ST_COUNT;
          ST_COUNT: phase <= ST_WDATA;
          default:  ;
        endcase
      end
      // transmit side of a read
      if (phase == ST_RDATA) begin
        if (sclFall && !ackSlot && bitCnt != 4'd0) begin
          shiftOut <= {shiftOut[6:0], 1'b1};
        end
        // last data bit is held through scl high; letting go of it
        // early would look like a stop to the host
        if (sclFall && ackSlot && bitCnt != 4'd8) begin
          shiftOut <= 8'hff;
        end
        // bitCnt 8 marks that the host's acknowledge bit was sampled
        if (sclRise && ackSlot) begin
          bitCnt <= 4'd8;
        end
        if (sclFall && ackSlot && bitCnt == 4'd8) begin
          ackSlot <= 1'b0;
          bitCnt  <= 4'd0;
          if (hostNack) begin
            phase <= ST_IGNORE;
          end else if (firstRead) begin
            firstRead <= 1'b0;
            shiftOut  <= readData;
          end else begin
            index    <= index + 8'h01;
            shiftOut <= (index + 8'h01 <= REG_LEN) ? next_rd : RSVD_VALUE;
          end
        end
      end
    end
  end

  // next byte of a read, looked up one index ahead
  always_comb begin
    unique case (index + 8'h01)
      REG_PLL:    next_rd = {latchedMode, pllReg[5:0]};
      REG_SLEW:   next_rd = slewReg;
      REG_FREQ:   next_rd = freqReg;
      REG_RSVD:   next_rd = RSVD_VALUE;
      REG_REVVEN: next_rd = {REVISION_CODE, VENDOR_CODE};
      REG_TYPEID: next_rd = {PART_TYPE, PART_ID};
      REG_LEN:    next_rd = lenReg;
      default:    next_rd = oeReg;
    endcase
  end

  // ************************************************************
  // pin drive and decoded outputs
  // ************************************************************
  // shiftOut is all ones through the host's acknowledge slot
  wire txBit = (phase == ST_RDATA) & ~shiftOut[7];
  assign smbDataOut = 1'b0;
  assign smbDataOe  = driveLow | txBit;

  // pll mode 10 has no defined meaning and decodes as reserved
  wire [1:0] modeSel = pllReg[SWSEL_BIT] ? pllReg[4:3] : latchedMode;
  wire       fselOk  = freqReg[FSEL_EN_BIT] & (freqReg[4:3] != 2'b11);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      clockCfg <= '{1'b1, 1'b1, PLL_LOW_BW, 2'b10, 1'b1, 1'b1, 1'b1,
                    1'b0, 2'b00};
    end else begin
      clockCfg.output1Enable   <= oeReg[OE1_BIT];
      clockCfg.output0Enable   <= oeReg[OE0_BIT];
      clockCfg.pllMode         <= pll_mode_t'(modeSel);
      clockCfg.amplitude       <= pllReg[1:0];
      clockCfg.output1Slew     <= slewReg[5];
      clockCfg.output0Slew     <= slewReg[3];
      clockCfg.feedbackSlew    <= freqReg[FB_SLEW_BIT];
      clockCfg.freqSelectValid <= fselOk;
      clockCfg.freqCode        <= fselOk ? freqReg[4:3] : 2'b00;
    end
  end
endmodule
`default_nettype wire

// ### verif/smbus_clock_buffer_config_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_clock_buffer_config_regs_checker
  import smbus_clock_buffer_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // smbus pins
  input wire logic       smbClk,
  input wire logic       smbDataIn,
  input wire logic       smbDataOut,
  input wire logic       smbDataOe,
  // strap and configuration
  input wire logic [1:0] bandwidthModePin,
  input wire clock_cfg_t clockCfg
);
  // ************************************************************
  // pin and configuration relations
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // scl high this long only happens between frames
  sequence s_scl_idle;
    smbClk [*8];
  endsequence
  sequence s_held;
    smbDataOe [*4];
  endsequence
  property p_open_drain;
    smbDataOut == 1'b0;
  endproperty
  property p_oe_rise_low;
    $rose(smbDataOe) |-> !smbClk;
  endproperty
  property p_oe_fall_low;
    $fell(smbDataOe) |-> !smbClk;
  endproperty
  property p_oe_hold;
    $rose(smbDataOe) |=> s_held;
  endproperty
  property p_idle_release;
    s_scl_idle |-> !smbDataOe;
  endproperty
  property p_cfg_on_clk_high;
    $changed(clockCfg) |-> smbClk;
  endproperty
  property p_cfg_settle;
    $changed(clockCfg) |=> $stable(clockCfg) [*4];
  endproperty
  property p_fsel_valid;
    clockCfg.freqSelectValid |-> clockCfg.freqCode != 2'b11;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  a_oe_rise_low: assert property (p_oe_rise_low) else $error("oe rose, scl high");
  a_oe_fall_low: assert property (p_oe_fall_low) else $error("oe fell, scl high");
  a_oe_hold: assert property (p_oe_hold) else $error("oe pulse too short");
  a_idle_release: assert property (p_idle_release) else $error("oe while idle");
  a_cfg_on_clk_high: assert property (p_cfg_on_clk_high) else $error("cfg moved");
  a_cfg_settle: assert property (p_cfg_settle) else $error("cfg unsettled");
  a_fsel_valid: assert property (p_fsel_valid) else $error("fsel 11 valid");
endmodule
bind smbus_clock_buffer_config_regs smbus_clock_buffer_config_regs_checker u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .smbClk(smbClk), .smbDataIn(smbDataIn),
  .smbDataOut(smbDataOut), .smbDataOe(smbDataOe),
  .bandwidthModePin(bandwidthModePin), .clockCfg(clockCfg));
`default_nettype wire

// ### verif/smbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  // host side of the bus
  output logic      scl,
  output logic      sdaPull,
  input  wire logic sdaLine
);
  // ************************************************************
  // bit level; sda moves 8 ns after scl falls so a synced target
  // never sees it change while scl is still high
  // ************************************************************
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic start();
    #8 sdaPull = 1'b0;
    #16 scl = 1'b1;
    #16 sdaPull = 1'b1;
    #16 scl = 1'b0;
  endtask
  task automatic stop();
    #8 sdaPull = 1'b1;
    #16 scl = 1'b1;
    #16 sdaPull = 1'b0;
    #64;
  endtask
  task automatic bitX(input logic b, output logic seen);
    #8 sdaPull = ~b;
    #24 scl = 1'b1;
    #24 seen = sdaLine;
    #8 scl = 1'b0;
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitX(b[i], s);
    bitX(1'b1, s);
    ack = ~s;
  endtask
  task automatic recvByte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bitX(1'b1, b[i]);
    bitX(last, s);
  endtask
endmodule
`default_nettype wire

// ### verif/smbus_clock_buffer_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module smbus_clock_buffer_config_regs_tb_top;
  import smbus_clock_buffer_pkg::*;
  // identity values are arbitrary
  localparam logic [7:0] REVVEN = 8'h96;
  localparam logic [7:0] TYPEID = 8'h55;
  logic       mclk;
  logic       sys_rst;
  logic       smbClk;
  logic       hostPull;
  logic       smbDataOut;
  logic       smbDataOe;
  logic [1:0] bandwidthModePin;
  clock_cfg_t clockCfg;
  wire logic  sdaLine = ~(hostPull | smbDataOe);
  int         fails;
  int         checks;
  int         cyc;
  logic       ack;
  logic [7:0] rd [0:8];
  logic [7:0] wd [$];
  smbus_clock_buffer_config_regs #(.REVISION_CODE(4'h9),
    .VENDOR_CODE(4'h6), .PART_TYPE(2'h1), .PART_ID(6'h15)) DUT (
    .mclk(mclk), .sys_rst(sys_rst), .smbClk(smbClk), .smbDataIn(sdaLine),
    .smbDataOut(smbDataOut), .smbDataOe(smbDataOe),
    .bandwidthModePin(bandwidthModePin), .clockCfg(clockCfg));
  smbus_host_model host (.scl(smbClk), .sdaPull(hostPull),
    .sdaLine(sdaLine));
  // ************************************************************
  // transfers
  // ************************************************************
  task automatic wrBlock(input logic [6:0] adr, input logic [7:0] idx);
    host.start();
    host.sendByte({adr, 1'b0}, ack);
    `CHK("addr ack", adr == TARGET_ADDR, ack)
    if (ack === 1'b1) begin
      host.sendByte(idx, ack);
      `CHK("index ack", 1'b1, ack)
      host.sendByte(8'(wd.size()), ack);
      `CHK("count ack", 1'b1, ack)
      foreach (wd[i]) begin
        host.sendByte(wd[i], ack);
        `CHK("data ack", 1'b1, ack)
      end
    end
    host.stop();
  endtask
  task automatic chkRead(input logic [7:0] idx, input logic [7:0] e [$]);
    host.start();
    host.sendByte({TARGET_ADDR, 1'b0}, ack);
    `CHK("rd addr ack", 1'b1, ack)
    host.sendByte(idx, ack);
    `CHK("rd index ack", 1'b1, ack)
    host.start();
    host.sendByte({TARGET_ADDR, 1'b1}, ack);
    `CHK("rd dir ack", 1'b1, ack)
    foreach (e[i]) host.recvByte(i == e.size() - 1, rd[i]);
    host.stop();
    foreach (e[i]) `CHK("read byte", e[i], rd[i])
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    bandwidthModePin = 2'b01;
    repeat (10) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (5) @(posedge mclk);
    `CHK("reset cfg", clock_cfg_t'{1, 1, PLL_BYPASS, 2'b10, 1, 1, 1, 0, 0}, clockCfg)
    chkRead(8'h00, '{8'h08, 8'hff, 8'h46, 8'hff, 8'h07, 8'hff, REVVEN, TYPEID, 8'h08});
    wd = '{8'h00, 8'h3f, 8'h00, 8'h31, 8'h00, 8'h00, 8'h00, 8'h03};
    wrBlock(TARGET_ADDR, 8'h00);
    `CHK("sw cfg", clock_cfg_t'{0, 0, PLL_HIGH_BW, 2'b11, 0, 0, 1, 1, 2'b10}, clockCfg)
    chkRead(8'h00, '{8'h03, 8'hd7, 8'h7f, 8'hd7});
    chkRead(8'h04, '{8'h03, 8'hff, REVVEN, TYPEID});
    wd = '{8'h18, 8'h28, 8'h39};
    wrBlock(TARGET_ADDR, 8'h01);
    `CHK("latched cfg", clock_cfg_t'{0, 0, PLL_BYPASS, 2'b00, 1, 1, 1, 0, 2'b00}, clockCfg)
    chkRead(8'h01, '{8'h03, 8'h5c, 8'hff, 8'h3f});
    wd = '{8'hff};
    wrBlock(7'h6c, 8'h00);
    `CHK("foreign addr", clock_cfg_t'{0, 0, PLL_BYPASS, 2'b00, 1, 1, 1, 0, 2'b00}, clockCfg)
    print_verdict();
  end
endmodule
`default_nettype wire
